//--- acp_attr_palette.v
// Purpose: Attribute controller back end and colour palette host access
// Assumes: Host I/O strobes are one-cycle pulses synchronous to mclk
// Notes: Read data registered one cycle after io_rd; colour registers held in an internal 256-entry array
`timescale 1ns/1ps
`include "acp_defines.vh"
module acp_attr_palette (
    mclk,
    rst,
    io_addr,
    io_wr,
    io_rd,
    io_wdata,
    io_rdata,
    io_rvalid,
    dot_en,
    disp_en,
    blank,
    nine_dot,
    plane_pix,
    attr_color,
    video_out,
    pal_rgb,
    stat_bits
);
    input wire mclk;
    input wire rst;
    input wire [15:0] io_addr;
    input wire io_wr;
    input wire io_rd;
    input wire [7:0] io_wdata;
    output reg [7:0] io_rdata;
    output reg io_rvalid;
    input wire dot_en;
    input wire disp_en;
    input wire blank;
    input wire nine_dot;
    input wire [3:0] plane_pix;
    input wire [5:0] attr_color;
    output reg [7:0] video_out;
    output reg [17:0] pal_rgb;
    output reg [1:0] stat_bits;

    // ****************************************
    // Host register state
    // ****************************************
    reg attr_ff_reg;
    reg [5:0] attr_index_port_reg;
    reg [7:0] attr_mode_control_reg;
    reg [7:0] border_color_reg;
    reg [7:0] plane_enable_reg;
    reg [7:0] pixel_pan_reg;
    reg [7:0] pad_bits_reg;
    reg [7:0] palette_pixel_mask_reg;
    reg [1:0] pal_state_reg;
    reg [7:0] palette_index_reg;
    reg [7:0] save_reg;
    reg [1:0] seq_reg;
    reg [17:0] palette_entry_mem [0:255];

    wire [17:0] cur_entry = palette_entry_mem[save_reg];
    wire data_acc = (io_wr | io_rd) && io_addr == `ACP_PORT_DATA;
    wire stat_rd = io_rd && (io_addr == `ACP_PORT_STAT_MONO || io_addr == `ACP_PORT_STAT_COLOR);
    wire asm_mode = attr_mode_control_reg[`ACP_MODE_ASM];

    function [7:0] attr_read;
        input [4:0] idx;
        begin
            case (idx)
                `ACP_IDX_MODE: attr_read = attr_mode_control_reg;
                `ACP_IDX_BORDER: attr_read = border_color_reg;
                `ACP_IDX_PLANE: attr_read = {2'h0, plane_enable_reg[5:0]};
                `ACP_IDX_PAN: attr_read = {4'h0, pixel_pan_reg[3:0]};
                `ACP_IDX_PAD: attr_read = {4'h0, pad_bits_reg[3:0]};
                default: attr_read = 8'h00;
            endcase
        end
    endfunction

    // ****************************************
    // Host writes
    // ****************************************
    always @(posedge mclk)
    begin
        if (rst)
        begin
            attr_ff_reg <= 1'b0;
            attr_index_port_reg <= 6'h00;
            attr_mode_control_reg <= `ACP_RST_BYTE;
            border_color_reg <= `ACP_RST_BYTE;
            plane_enable_reg <= `ACP_RST_BYTE;
            pixel_pan_reg <= `ACP_RST_BYTE;
            pad_bits_reg <= `ACP_RST_BYTE;
            palette_pixel_mask_reg <= `ACP_RST_MASK;
            pal_state_reg <= `ACP_STATE_WRITE;
            palette_index_reg <= 8'h00;
            save_reg <= 8'h00;
            seq_reg <= `ACP_SEQ_RED;
        end
        else
        begin
            if (io_wr && io_addr == `ACP_PORT_ATTR_IDX)
            begin
                attr_ff_reg <= ~attr_ff_reg;
                if (!attr_ff_reg)
                    attr_index_port_reg <= io_wdata[5:0];
                else
                begin
                    case (attr_index_port_reg[4:0])
                        `ACP_IDX_MODE: attr_mode_control_reg <= io_wdata;
                        `ACP_IDX_BORDER: border_color_reg <= io_wdata;
                        `ACP_IDX_PLANE: plane_enable_reg <= io_wdata;
                        `ACP_IDX_PAN: pixel_pan_reg <= io_wdata;
                        `ACP_IDX_PAD: pad_bits_reg <= io_wdata;
                        default: ;
                    endcase
                end
            end
            else if (stat_rd)
                attr_ff_reg <= 1'b0;
            if (io_wr && io_addr == `ACP_PORT_MASK)
                palette_pixel_mask_reg <= io_wdata;
            if (io_wr && io_addr == `ACP_PORT_RD_IDX)
            begin
                save_reg <= io_wdata;
                palette_index_reg <= io_wdata + 8'h01;
                pal_state_reg <= `ACP_STATE_READ;
                seq_reg <= `ACP_SEQ_RED;
            end
            else if (io_wr && io_addr == `ACP_PORT_WR_IDX)
            begin
                save_reg <= io_wdata;
                palette_index_reg <= io_wdata;
                pal_state_reg <= `ACP_STATE_WRITE;
                seq_reg <= `ACP_SEQ_RED;
            end
            else if (data_acc)
            begin
                if (seq_reg == `ACP_SEQ_BLUE)
                begin
                    seq_reg <= `ACP_SEQ_RED;
                    save_reg <= save_reg + 8'h01;
                    palette_index_reg <= palette_index_reg + 8'h01;
                end
                else
                    seq_reg <= seq_reg + 2'h1;
            end
        end
    end

    // Palette array: red in 17-12, green 11-6, blue 5-0
    always @(posedge mclk)
    begin
        if (io_wr && io_addr == `ACP_PORT_DATA && !rst)
        begin
            case (seq_reg)
                `ACP_SEQ_RED: palette_entry_mem[save_reg] <= {io_wdata[5:0], cur_entry[11:0]};
                `ACP_SEQ_GREEN: palette_entry_mem[save_reg] <= {cur_entry[17:12], io_wdata[5:0],
                    cur_entry[5:0]};
                default: palette_entry_mem[save_reg] <= {cur_entry[17:6], io_wdata[5:0]};
            endcase
        end
    end

    // ****************************************
    // Host reads
    // ****************************************
    always @(posedge mclk)
    begin
        if (rst)
        begin
            io_rdata <= 8'h00;
            io_rvalid <= 1'b0;
        end
        else
        begin
            io_rvalid <= io_rd;
            if (io_rd)
            begin
                case (io_addr)
                    `ACP_PORT_ATTR_IDX: io_rdata <= {2'h0, attr_index_port_reg};
                    `ACP_PORT_ATTR_DAT: io_rdata <= attr_read(attr_index_port_reg[4:0]);
                    `ACP_PORT_STAT_MONO, `ACP_PORT_STAT_COLOR: io_rdata <= {2'h0, stat_bits, 4'h0};
                    `ACP_PORT_MASK: io_rdata <= palette_pixel_mask_reg;
                    `ACP_PORT_RD_IDX: io_rdata <= {6'h00, pal_state_reg};
                    `ACP_PORT_WR_IDX: io_rdata <= palette_index_reg;
                    `ACP_PORT_DATA:
                    begin
                        case (seq_reg)
                            `ACP_SEQ_RED: io_rdata <= {2'h0, cur_entry[17:12]};
                            `ACP_SEQ_GREEN: io_rdata <= {2'h0, cur_entry[11:6]};
                            default: io_rdata <= {2'h0, cur_entry[5:0]};
                        endcase
                    end
                    default: io_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************
    // Pixel path
    // ****************************************
    wire [3:0] gated_pix = plane_pix & plane_enable_reg[3:0];
    reg [7:0] attr_byte;
    reg [3:0] pan_amt;
    always @*
    begin
        attr_byte[3:0] = attr_color[3:0];
        attr_byte[5:4] = attr_mode_control_reg[`ACP_MODE_SEL54] ? pad_bits_reg[1:0]
            : attr_color[5:4];
        attr_byte[7:6] = pad_bits_reg[3:2];
        if (asm_mode)
            pan_amt = {1'b0, pixel_pan_reg[3:1]};
        else if (nine_dot && !attr_mode_control_reg[`ACP_MODE_GFX])
            pan_amt = (pixel_pan_reg[3:0] >= 4'h8) ? 4'h0 : pixel_pan_reg[3:0] + 4'h1;
        else
            pan_amt = (pixel_pan_reg[3:0] >= 4'h8) ? 4'h0 : pixel_pan_reg[3:0];
    end

    // 256-colour assembler: half rate byte from two nibbles
    reg asm_phase_reg;
    reg [3:0] asm_hi_reg;
    reg [7:0] asm_byte_reg;
    always @(posedge mclk)
    begin
        if (rst)
        begin
            asm_phase_reg <= 1'b0;
            asm_hi_reg <= 4'h0;
            asm_byte_reg <= 8'h00;
        end
        else if (dot_en)
        begin
            asm_phase_reg <= asm_mode ? ~asm_phase_reg : 1'b0;
            if (!asm_phase_reg)
                asm_hi_reg <= gated_pix;
            else
                asm_byte_reg <= {asm_hi_reg, gated_pix};
        end
    end

    wire [7:0] pix_byte = asm_mode ? asm_byte_reg : attr_byte;
    wire [7:0] pan_out;
    acp_panner #(.W(8), .DEPTH(9)) u_pan (
        .mclk(mclk),
        .rst(rst),
        .en(dot_en),
        .shift(pan_amt),
        .din(pix_byte),
        .dout(pan_out)
    );

    reg [7:0] vid;
    always @*
    begin
        if (!disp_en && !blank)
            vid = border_color_reg;
        else if (blank)
            vid = 8'h00;
        else
            vid = pan_out;
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            video_out <= 8'h00;
            pal_rgb <= 18'h00000;
            stat_bits <= 2'h0;
        end
        else if (dot_en)
        begin
            video_out <= vid & palette_pixel_mask_reg;
            pal_rgb <= palette_entry_mem[vid & palette_pixel_mask_reg];
            case (plane_enable_reg[5:4])
                2'h0: stat_bits <= {vid[2], vid[0]};
                2'h1: stat_bits <= {vid[5], vid[4]};
                2'h2: stat_bits <= {vid[3], vid[1]};
                default: stat_bits <= {vid[7], vid[6]};
            endcase
        end
    end
endmodule // acp_attr_palette

//--- acp_defines.vh
// Purpose: Constants for the attribute back end and palette host access
// Assumes: Byte I/O port addresses decoded as 16-bit values
// Notes: Attribute indices and palette ports are the hardware's own map
`ifndef ACP_DEFINES_VH
`define ACP_DEFINES_VH

// I/O ports
`define ACP_PORT_ATTR_IDX 16'h03C0
`define ACP_PORT_ATTR_DAT 16'h03C1
`define ACP_PORT_STAT_MONO 16'h03BA
`define ACP_PORT_STAT_COLOR 16'h03DA
`define ACP_PORT_MASK 16'h03C6
`define ACP_PORT_RD_IDX 16'h03C7
`define ACP_PORT_WR_IDX 16'h03C8
`define ACP_PORT_DATA 16'h03C9

// Attribute indices
`define ACP_IDX_MODE 5'h10
`define ACP_IDX_BORDER 5'h11
`define ACP_IDX_PLANE 5'h12
`define ACP_IDX_PAN 5'h13
`define ACP_IDX_PAD 5'h14

// Field positions
`define ACP_MODE_GFX 0
`define ACP_MODE_LGE 2
`define ACP_MODE_ASM 6
`define ACP_MODE_SEL54 7

// Reset values and palette state codes
`define ACP_RST_BYTE 8'h00
`define ACP_RST_MASK 8'hFF
`define ACP_STATE_WRITE 2'h0
`define ACP_STATE_READ 2'h3

// Colour sequence positions
`define ACP_SEQ_RED 2'h0
`define ACP_SEQ_GREEN 2'h1
`define ACP_SEQ_BLUE 2'h2

`endif

//--- acp_panner.v
// Purpose: Horizontal pixel panning delay line
// Assumes: One pixel per dot enable
// Notes: Delays the pixel stream by a selectable count of pixels
`timescale 1ns/1ps
module acp_panner #(
    parameter W = 8,
    parameter DEPTH = 9
)(
    mclk,
    rst,
    en,
    shift,
    din,
    dout
);
    input wire mclk;
    input wire rst;
    input wire en;
    input wire [3:0] shift;
    input wire [W-1:0] din;
    output reg [W-1:0] dout;

    reg [W-1:0] tap_reg [0:DEPTH-1];
    integer i;

    // ****************************************
    // Tap line: larger shift selects a newer pixel ahead in time
    // ****************************************
    always @(posedge mclk)
    begin
        if (rst)
        begin
            for (i = 0; i < DEPTH; i = i + 1)
                tap_reg[i] <= {W{1'b0}};
            dout <= {W{1'b0}};
        end
        else if (en)
        begin
            tap_reg[0] <= din;
            for (i = 1; i < DEPTH; i = i + 1)
                tap_reg[i] <= tap_reg[i-1];
            dout <= (shift == 4'h0) ? tap_reg[DEPTH-1] : tap_reg[DEPTH-1-shift];
        end
    end
endmodule // acp_panner

//--- acp_attr_palette_asserts.sv
// Purpose: Port-level checks of the palette and attribute host access
// Assumes: I/O strobes are one-cycle pulses on mclk
// Notes: Bound to the top module from the testbench file
`timescale 1ns/1ps
`include "acp_defines.vh"
module acp_attr_palette_asserts (
    input wire mclk,
    input wire rst,
    input wire [15:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    input wire [7:0] io_rdata,
    input wire io_rvalid,
    input wire [1:0] stat_bits
);
    // ********
    // Port decode helpers
    // ********
    wire wr_rx = io_wr && io_addr == `ACP_PORT_RD_IDX;
    wire wr_wx = io_wr && io_addr == `ACP_PORT_WR_IDX;
    wire rd_rx = io_rd && io_addr == `ACP_PORT_RD_IDX;
    wire rd_wx = io_rd && io_addr == `ACP_PORT_WR_IDX;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    AST_RD_ANSWER: assert property (io_rd |=> io_rvalid)
        else $error("read not answered");
    AST_RD_QUIET: assert property (!io_rd |=> !io_rvalid && $stable(io_rdata))
        else $error("read data moved without a read");
    AST_STATE_RX: assert property (wr_rx ##1 rd_rx |=> io_rdata == 8'h03)
        else $error("state not 11 after read-mode index");
    AST_STATE_WX: assert property (wr_wx ##1 rd_rx |=> io_rdata == 8'h00)
        else $error("state not 00 after write-mode index");
    AST_IDX_RX: assert property (wr_rx ##1 rd_wx |=>
        io_rdata == $past(io_wdata, 2) + 8'h01) else $error("index not one past value");
    AST_IDX_WX: assert property (wr_wx ##1 rd_wx |=>
        io_rdata == $past(io_wdata, 2)) else $error("index not as written");
    AST_COLOR_TOP: assert property (io_rd && io_addr == `ACP_PORT_DATA |=>
        io_rdata[7:6] == 2'h0) else $error("colour byte upper bits set");
    AST_STAT_READ: assert property (io_rd && io_addr == `ACP_PORT_STAT_COLOR |=>
        io_rdata[5:4] == $past(stat_bits)) else $error("status bits differ from output");
endmodule // acp_attr_palette_asserts

//--- acp_host.sv
// Purpose: Host processor model issuing byte I/O cycles
// Assumes: Tasks are entered just after a rising edge of mclk
// Notes: Strobes stay up between back-to-back cycles; idle lowers them
`timescale 1ns/1ps
`include "acp_defines.vh"
module acp_host (
    input wire mclk,
    input wire [7:0] io_rdata,
    output logic [15:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata
);
    // ********
    // Bus cycles
    // ********
    initial
    begin
        io_addr = 16'h0000;
        io_wr = 1'h0;
        io_rd = 1'h0;
        io_wdata = 8'h00;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        io_addr = a;
        io_wdata = v;
        io_rd = 1'h0;
        io_wr = 1'h1;
        @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        io_addr = a;
        io_wr = 1'h0;
        io_rd = 1'h1;
        @(posedge mclk);
        #1;
        v = io_rdata;
    endtask
    task automatic idle();
        io_wr = 1'h0;
        io_rd = 1'h0;
        @(posedge mclk);
        #1;
    endtask
    // Colour position cannot be saved, so the three bytes go out unbroken
    task automatic put_rgb(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
        wr(`ACP_PORT_DATA, r);
        wr(`ACP_PORT_DATA, g);
        wr(`ACP_PORT_DATA, b);
    endtask
endmodule // acp_host

//--- testbench.sv
// Purpose: Self-checking bench for the attribute back end and palette
// Assumes: Host model drives every I/O strobe
// Notes: Pixel inputs set per scenario and flipped by pan_lat; border and pixel paths both carry video checks
`timescale 1ns/1ps
`include "acp_defines.vh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module testbench;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic blank = 1'h0;
    logic disp_en = 1'h0;
    logic nine_dot = 1'h0;
    logic [3:0] plane_pix = 4'h0;
    logic [5:0] attr_color = 6'h00;
    wire [17:0] pal_rgb;
    int cyc = 0;
    int n0;
    int n;
    wire [15:0] io_addr;
    wire io_wr;
    wire io_rd;
    wire [7:0] io_wdata;
    wire [7:0] io_rdata;
    wire [7:0] video_out;
    wire [1:0] stat_bits;
    int checked = 0;
    int n_mismatch = 0;
    logic [7:0] d;
    logic [23:0] rows [5] = '{24'h100000, 24'h11A5A5, 24'h12FF3F, 24'h13FF0F, 24'h14F000};
    logic [7:0] st_exp = 8'h8B;
    logic [23:0] pal_exp = 24'h012A3F;
    always #2 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    acp_host u_acp_host (.mclk(mclk), .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata));
    acp_attr_palette u_acp_attr_palette (.mclk(mclk), .rst(rst), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rvalid(), .dot_en(1'h1), .disp_en(disp_en), .blank(blank), .nine_dot(nine_dot),
        .plane_pix(plane_pix), .attr_color(attr_color), .video_out(video_out), .pal_rgb(pal_rgb),
        .stat_bits(stat_bits));
    // ********
    // Helpers
    // ********
    task automatic rdchk(input logic [15:0] a, input logic [7:0] ex);
        logic [7:0] got;
        u_acp_host.rd(a, got);
        `CHK("io_rdata", ex, got)
    endtask
    task automatic aw(input logic [4:0] ix, input logic [7:0] v);
        u_acp_host.wr(`ACP_PORT_ATTR_IDX, {3'h1, ix});
        u_acp_host.wr(`ACP_PORT_ATTR_IDX, v);
    endtask
    task automatic settle();
        u_acp_host.idle();
        repeat (20) @(posedge mclk);
        #1;
    endtask
    // Edges from a flip of both pixel inputs (attr_color and plane_pix) until video_out follows, started on an even cycle
    task automatic pan_lat(output int cnt);
        logic [7:0] v0;
        settle();
        while (cyc[0] == 1'b1)
        begin
            @(posedge mclk);
            #1;
        end
        v0 = video_out;
        attr_color = ~attr_color;
        plane_pix = ~plane_pix;
        cnt = 0;
        while (video_out == v0 && cnt < 40)
        begin
            @(posedge mclk);
            #1;
            cnt++;
        end
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    initial
    begin
        repeat (10) @(posedge mclk);
        #1;
        rst = 1'h0;
        rdchk(`ACP_PORT_MASK, 8'hFF);
        rdchk(`ACP_PORT_RD_IDX, 8'h00);
        u_acp_host.rd(`ACP_PORT_STAT_COLOR, d);
        foreach (rows[i])
        begin
            aw(rows[i][20:16], rows[i][15:8]);
            rdchk(`ACP_PORT_ATTR_IDX, {3'h1, rows[i][20:16]});
            rdchk(`ACP_PORT_ATTR_DAT, rows[i][7:0]);
        end
        for (int i = 0; i < 4; i++)
        begin
            u_acp_host.rd(`ACP_PORT_STAT_COLOR, d);
            aw(`ACP_IDX_PLANE, {2'h0, i[1:0], 4'hF});
            settle();
            `CHK("stat_bits", st_exp[2*i +: 2], stat_bits)
        end
        `CHK("video_out", 8'hA5, video_out)
        blank = 1'h1;
        settle();
        `CHK("video_out", 8'h00, video_out)
        blank = 1'h0;
        u_acp_host.wr(`ACP_PORT_MASK, 8'h0F);
        settle();
        `CHK("video_out", 8'h05, video_out)
        rdchk(`ACP_PORT_MASK, 8'h0F);
        u_acp_host.wr(`ACP_PORT_WR_IDX, 8'h05);
        rdchk(`ACP_PORT_WR_IDX, 8'h05);
        u_acp_host.put_rgb(8'hFF, 8'h2A, 8'hC1);
        rdchk(`ACP_PORT_WR_IDX, 8'h06);
        u_acp_host.wr(`ACP_PORT_RD_IDX, 8'h05);
        rdchk(`ACP_PORT_WR_IDX, 8'h06);
        rdchk(`ACP_PORT_DATA, 8'h3F);
        u_acp_host.wr(`ACP_PORT_RD_IDX, 8'h05);
        rdchk(`ACP_PORT_RD_IDX, 8'h03);
        for (int i = 0; i < 3; i++)
        begin
            rdchk(`ACP_PORT_DATA, pal_exp[8*i +: 8]);
        end
        rdchk(`ACP_PORT_WR_IDX, 8'h07);
        u_acp_host.wr(`ACP_PORT_WR_IDX, 8'h00);
        rdchk(`ACP_PORT_RD_IDX, 8'h00);
        aw(`ACP_IDX_BORDER, 8'h05);
        settle();
        `CHK("pal_rgb", 18'h3FA81, pal_rgb)
        u_acp_host.wr(`ACP_PORT_MASK, 8'hFF);
        aw(`ACP_IDX_PAD, 8'h0B);
        disp_en = 1'h1;
        attr_color = 6'h2A;
        settle();
        `CHK("video_out", 8'hAA, video_out)
        aw(`ACP_IDX_MODE, 8'h80);
        settle();
        `CHK("video_out", 8'hBA, video_out)
        aw(`ACP_IDX_PAN, 8'h00);
        pan_lat(n0);
        aw(`ACP_IDX_PAN, 8'h03);
        pan_lat(n);
        `CHK("pan", n0 - 3, n)
        nine_dot = 1'h1;
        aw(`ACP_IDX_PAN, 8'h08);
        pan_lat(n);
        `CHK("pan", n0, n)
        aw(`ACP_IDX_PAN, 8'h07);
        pan_lat(n);
        `CHK("pan", n0 - 8, n)
        aw(`ACP_IDX_MODE, 8'h40);
        aw(`ACP_IDX_PLANE, 8'h05);
        plane_pix = 4'hF;
        settle();
        `CHK("video_out", 8'h55, video_out)
        `CHK("stat_bits", 2'h3, stat_bits)
        aw(`ACP_IDX_PLANE, 8'h0F);
        aw(`ACP_IDX_PAN, 8'h00);
        pan_lat(n0);
        aw(`ACP_IDX_PAN, 8'h06);
        pan_lat(n);
        `CHK("pan", n0 - 3, n)
        u_acp_host.idle();
        rst = 1'h1;
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'h0;
        rdchk(`ACP_PORT_MASK, 8'hFF);
        rdchk(`ACP_PORT_RD_IDX, 8'h00);
        u_acp_host.idle();
        final_report();
    end
    initial
    begin
        #20000;
        n_mismatch++;
        final_report();
    end
endmodule // testbench
bind acp_attr_palette acp_attr_palette_asserts u_acp_attr_palette_asserts (.mclk(mclk),
    .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .stat_bits(stat_bits));
